// ### rtl/fei_pkg.sv
// shared constants for the fifo expansion interlock host controller
// assumes a 20 MHz core clock driving an array of 64x4 fall-through slices
package fei_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned SLICE_BITS      = 4;
  localparam int unsigned SLICE_WORDS     = 63;
  localparam int unsigned DEF_ROW_SLICES  = 1;
  localparam int unsigned DEF_COL_SLICES  = 1;
  localparam int unsigned SYNC_STAGES     = 2;

  // least pulse widths and recovery times, in ns
  localparam int unsigned MR_LOW_NS       = 9;
  localparam int unsigned MR_RECOVERY_NS  = 15;
  localparam int unsigned PL_HIGH_NS      = 9;
  localparam int unsigned TOP_LOW_NS      = 7;

  // least times round up, none below one cycle
  function automatic int unsigned fei_min_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : fei_min_cycles

  localparam int unsigned MR_LOW_CYC      = fei_min_cycles(MR_LOW_NS);
  localparam int unsigned MR_RECOVERY_CYC = fei_min_cycles(MR_RECOVERY_NS);
  localparam int unsigned PL_HIGH_CYC     = fei_min_cycles(PL_HIGH_NS);
  localparam int unsigned TOP_LOW_CYC     = fei_min_cycles(TOP_LOW_NS);
  // cycles after the load strobe before the synchronised full flag is trusted
  localparam int unsigned WR_SETTLE_CYC   = SYNC_STAGES + 1;

  localparam logic [3:0]  CNT_ZERO        = 4'h0;

  typedef enum logic [1:0] {
    FEI_INIT_RESET = 2'b00,
    FEI_INIT_RECOV = 2'b01,
    FEI_INIT_DONE  = 2'b10
  } fei_init_type;

  typedef enum logic [1:0] {
    FEI_WR_IDLE   = 2'b00,
    FEI_WR_LOAD   = 2'b01,
    FEI_WR_SETTLE = 2'b10,
    FEI_WR_WAIT   = 2'b11
  } fei_wr_type;

  typedef enum logic [1:0] {
    FEI_RD_REQ   = 2'b00,
    FEI_RD_HOLD  = 2'b01,
    FEI_RD_DROP  = 2'b10,
    FEI_RD_EMPTY = 2'b11
  } fei_rd_type;

endpackage : fei_pkg

// ### rtl/fei_sync.sv
// two-stage synchroniser for pin levels from the slice array
// assumes the inputs are quasi-static levels from outside core_clk
`timescale 1ns/1ps
module fei_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // only the second stage is read; the first may still be settling
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : fei_sync

// ### rtl/fei_host.sv
// host controller for an m x n array of fall-through fifo slices
// assumes slices are wired for parallel load and parallel extraction;
// all status pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
module fei_host
#(
  parameter int unsigned ROW_SLICES = fei_pkg::DEF_ROW_SLICES,
  parameter int unsigned COL_SLICES = fei_pkg::DEF_COL_SLICES,
  parameter int unsigned DW         = fei_pkg::SLICE_BITS * ROW_SLICES,
  parameter int unsigned DEPTH      = fei_pkg::SLICE_WORDS * COL_SLICES + 1,
  parameter int unsigned LW         = $clog2(DEPTH + 1)
) (
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // user write side
  input  wire logic          wr_valid,
  input  wire logic [DW-1:0] wr_data,
  output logic               wr_ready,
  // user read side
  output logic               rd_valid,
  output logic [DW-1:0]      rd_data,
  input  wire logic          rd_ready,
  output logic [LW-1:0]      words_held,
  output logic               array_ready,
  // array pins
  output logic               master_reset_n,
  output logic               parallel_load,
  output logic [DW-1:0]      array_d,
  output logic               transfer_out_parallel,
  output logic               transfer_to_stack_n,
  output logic               transfer_out_serial_n,
  output logic               serial_in_enable_n,
  output logic               serial_in_shift_clock,
  output logic               serial_out_shift_clock,
  input  wire logic          last_input_full_n,
  input  wire logic          last_output_empty_n,
  input  wire logic          top_input_full_n,
  input  wire logic          top_output_empty_n,
  input  wire logic [DW-1:0] array_q
);

  import fei_pkg::*;

  localparam int unsigned SW = DW + 4;
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_q;
  logic          last_full_n_s;
  logic          last_empty_n_s;
  logic          top_full_n_s;
  logic          top_empty_n_s;
  logic [DW-1:0] q_s;

  fei_sync #(.WIDTH(SW)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (sync_in),
    .sync_out (sync_q)
  );

  assign sync_in = {last_input_full_n, last_output_empty_n,
                    top_input_full_n, top_output_empty_n, array_q};
  assign last_full_n_s  = sync_q[SW-1];
  assign last_empty_n_s = sync_q[SW-2];
  assign top_full_n_s   = sync_q[SW-3];
  assign top_empty_n_s  = sync_q[SW-4];
  assign q_s            = sync_q[DW-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // initialisation
  fei_init_type  init_ff;
  logic [3:0]    init_cnt_ff;
  logic          mr_n_ff;
  logic          ready_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      init_ff     <= FEI_INIT_RESET;
      init_cnt_ff <= CNT_ZERO;
      mr_n_ff     <= 1'b0;
      ready_ff    <= 1'b0;
    end else begin
      case (init_ff)
        FEI_INIT_RESET: begin
          if (init_cnt_ff >= 4'(MR_LOW_CYC - 1)) begin
            init_ff     <= FEI_INIT_RECOV;
            init_cnt_ff <= CNT_ZERO;
            mr_n_ff     <= 1'b1;
          end else begin
            init_cnt_ff <= init_cnt_ff + 4'h1;
          end
        end
        FEI_INIT_RECOV: begin
          // wait for every full flag high before use
          if (init_cnt_ff >= 4'(MR_RECOVERY_CYC - 1) && last_full_n_s && top_full_n_s) begin
            init_ff  <= FEI_INIT_DONE;
            ready_ff <= 1'b1;
          end else if (init_cnt_ff < 4'(MR_RECOVERY_CYC - 1)) begin
            init_cnt_ff <= init_cnt_ff + 4'h1;
          end
        end
        default: begin
          init_ff <= FEI_INIT_DONE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // expansion strobes and fixed pins
  logic tts_n_ff;
  logic tos_n_ff;
  logic ies_n_ff;
  logic sclk_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tts_n_ff <= 1'b1;
      tos_n_ff <= 1'b1;
      ies_n_ff <= 1'b0;
      sclk_ff  <= 1'b0;
    end else begin
      // transfer strobe follows top slice full flag
      tts_n_ff <= top_full_n_s | ~ready_ff;
      // serial transfer follows top slice empty flag
      tos_n_ff <= top_empty_n_s;
      ies_n_ff <= 1'b0;
      // parallel mode keeps shift clocks low
      sclk_ff  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write path
  fei_wr_type    wr_ff;
  logic [3:0]    wr_cnt_ff;
  logic          pl_ff;
  logic [DW-1:0] d_ff;
  logic          wr_ready_ff;
  logic          wr_take;

  assign wr_take = wr_valid && wr_ready_ff;
  // new word only after last slave full flag high
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ff       <= FEI_WR_IDLE;
      wr_cnt_ff   <= CNT_ZERO;
      pl_ff       <= 1'b0;
      d_ff        <= '0;
      wr_ready_ff <= 1'b0;
    end else begin
      case (wr_ff)
        FEI_WR_IDLE: begin
          if (wr_take) begin
            wr_ff       <= FEI_WR_LOAD;
            d_ff        <= wr_data;
            pl_ff       <= 1'b1;
            wr_ready_ff <= 1'b0;
            wr_cnt_ff   <= CNT_ZERO;
          end else begin
            wr_ready_ff <= ready_ff && last_full_n_s;
          end
        end
        FEI_WR_LOAD: begin
          if (wr_cnt_ff >= 4'(PL_HIGH_CYC - 1)) begin
            pl_ff     <= 1'b0;
            wr_ff     <= FEI_WR_SETTLE;
            wr_cnt_ff <= CNT_ZERO;
          end else begin
            wr_cnt_ff <= wr_cnt_ff + 4'h1;
          end
        end
        FEI_WR_SETTLE: begin
          if (wr_cnt_ff >= 4'(WR_SETTLE_CYC - 1)) begin
            wr_ff <= FEI_WR_WAIT;
          end else begin
            wr_cnt_ff <= wr_cnt_ff + 4'h1;
          end
        end
        default: begin
          // stays here while a full stack holds the flag low
          if (last_full_n_s) begin
            wr_ff       <= FEI_WR_IDLE;
            wr_ready_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path
  fei_rd_type    rd_ff;
  logic [3:0]    rd_cnt_ff;
  logic          top_ff;
  logic          rd_valid_ff;
  logic [DW-1:0] rd_data_ff;
  logic          rd_done;

  assign rd_done = rd_valid_ff && rd_ready;

  // capture only after last output slave empty flag high
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ff       <= FEI_RD_REQ;
      rd_cnt_ff   <= CNT_ZERO;
      top_ff      <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= '0;
    end else begin
      case (rd_ff)
        FEI_RD_REQ: begin
          top_ff <= ready_ff;
          if (ready_ff && top_ff && last_empty_n_s) begin
            rd_ff <= FEI_RD_HOLD;
          end
        end
        FEI_RD_HOLD: begin
          // one extra cycle lets the synchronised data settle behind the flag
          rd_data_ff  <= q_s;
          rd_valid_ff <= 1'b1;
          rd_ff       <= FEI_RD_DROP;
        end
        FEI_RD_DROP: begin
          if (rd_done) begin
            rd_valid_ff <= 1'b0;
            top_ff      <= 1'b0;
            rd_cnt_ff   <= CNT_ZERO;
            rd_ff       <= FEI_RD_EMPTY;
          end
        end
        default: begin
          if (rd_cnt_ff < 4'(TOP_LOW_CYC - 1)) begin
            rd_cnt_ff <= rd_cnt_ff + 4'h1;
          end else if (!last_empty_n_s) begin
            rd_ff <= FEI_RD_REQ;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // occupancy
  logic [LW-1:0] held_ff;

  // count bounded by the array depth
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      held_ff <= '0;
    end else if (!ready_ff) begin
      held_ff <= '0;
    end else if (wr_take && !rd_done) begin
      held_ff <= (held_ff < LW'(DEPTH)) ? held_ff + LW'(1) : held_ff;
    end else if (rd_done && !wr_take) begin
      held_ff <= (held_ff != '0) ? held_ff - LW'(1) : held_ff;
    end
  end

  assign wr_ready               = wr_ready_ff;
  assign rd_valid               = rd_valid_ff;
  assign rd_data                = rd_data_ff;
  assign words_held             = held_ff;
  assign array_ready            = ready_ff;
  assign master_reset_n         = mr_n_ff;
  assign parallel_load          = pl_ff;
  assign array_d                = d_ff;
  assign transfer_out_parallel  = top_ff;
  assign transfer_to_stack_n    = tts_n_ff;
  assign transfer_out_serial_n  = tos_n_ff;
  assign serial_in_enable_n     = ies_n_ff;
  assign serial_in_shift_clock  = sclk_ff;
  assign serial_out_shift_clock = sclk_ff;

endmodule : fei_host

// ### sim/fei_host_properties.sv
// checker on the host controller pins
// assumes bind onto fei_host with slice flags on the array pins
`timescale 1ns/1ps
module fei_host_chk #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned LW    = 7
) (
  input wire logic          core_clk,
  input wire logic          reset_n,
  input wire logic          wr_ready,
  input wire logic          rd_valid,
  input wire logic [LW-1:0] words_held,
  input wire logic          array_ready,
  input wire logic          master_reset_n,
  input wire logic          parallel_load,
  input wire logic          transfer_out_parallel,
  input wire logic          transfer_to_stack_n,
  input wire logic          transfer_out_serial_n,
  input wire logic          serial_in_enable_n,
  input wire logic          serial_in_shift_clock,
  input wire logic          serial_out_shift_clock,
  input wire logic          last_input_full_n,
  input wire logic          last_output_empty_n,
  input wire logic          top_input_full_n,
  input wire logic          top_output_empty_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  property p_tts;
    array_ready && $past(array_ready, 3) |-> transfer_to_stack_n == $past(top_input_full_n, 3);
  endproperty
  a_tts: assert property (p_tts) else $error("stack strobe off top flag");
  property p_tos;
    array_ready && $past(array_ready, 3) |-> transfer_out_serial_n == $past(top_output_empty_n, 3);
  endproperty
  a_tos: assert property (p_tos) else $error("serial strobe off top flag");
  property p_depth;
    words_held <= DEPTH;
  endproperty
  a_depth: assert property (p_depth) else $error("word count past depth");
  property p_wr_gate;
    wr_ready |-> array_ready && last_input_full_n;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write offered while full");
  property p_load;
    $rose(parallel_load) |-> $past(last_input_full_n, 3) ##1 !parallel_load;
  endproperty
  a_load: assert property (p_load) else $error("load before full flag high");
  property p_read;
    $rose(rd_valid) |-> $past(last_output_empty_n, 3) && $past(last_output_empty_n, 2);
  endproperty
  a_read: assert property (p_read) else $error("read before empty flag high");
  property p_ies;
    serial_in_enable_n == 1'b0;
  endproperty
  a_ies: assert property (p_ies) else $error("row master enable not low");
  property p_sclk;
    !serial_in_shift_clock && !serial_out_shift_clock;
  endproperty
  a_sclk: assert property (p_sclk) else $error("shift clock moved in parallel mode");
  property p_mr;
    parallel_load || wr_ready |-> array_ready && master_reset_n;
  endproperty
  a_mr: assert property (p_mr) else $error("array used before reset");
  c_full: cover property (words_held == DEPTH);
  c_load: cover property ($rose(parallel_load));
  c_read: cover property ($fell(rd_valid));
endmodule : fei_host_chk

bind fei_host fei_host_chk #(.DEPTH(DEPTH), .LW(LW)) chk_u (
  .core_clk               (core_clk),
  .reset_n                (reset_n),
  .wr_ready               (wr_ready),
  .rd_valid               (rd_valid),
  .words_held             (words_held),
  .array_ready            (array_ready),
  .master_reset_n         (master_reset_n),
  .parallel_load          (parallel_load),
  .transfer_out_parallel  (transfer_out_parallel),
  .transfer_to_stack_n    (transfer_to_stack_n),
  .transfer_out_serial_n  (transfer_out_serial_n),
  .serial_in_enable_n     (serial_in_enable_n),
  .serial_in_shift_clock  (serial_in_shift_clock),
  .serial_out_shift_clock (serial_out_shift_clock),
  .last_input_full_n      (last_input_full_n),
  .last_output_empty_n    (last_output_empty_n),
  .top_input_full_n       (top_input_full_n),
  .top_output_empty_n     (top_output_empty_n)
);

// ### sim/fei_slice_model.sv
// behavioural model of one 64 x 4 fall-through slice
// assumes step low stalls the slice to make it slow
`timescale 1ns/1ps
module fei_slice_model (
  input wire logic  core_clk,
  input wire logic  step,
  input wire logic  master_reset_n,
  input wire logic  parallel_load,
  input wire logic  [3:0] array_d,
  input wire logic  transfer_to_stack_n,
  input wire logic  transfer_out_parallel,
  input wire logic  serial_in_enable_n,
  input wire logic  serial_out_shift_clock,
  output logic      input_full_n,
  output logic      output_empty_n,
  output logic      [3:0] array_q
);
  logic [3:0] stk[$];
  logic [3:0] in_ff;
  logic       master_ff = 1'b0;
  logic       so_clk_q  = 1'b0;
  logic [1:0] so_cnt    = 2'h0;
  always @(posedge core_clk or negedge master_reset_n) begin
    if (!master_reset_n) begin
      if (!serial_in_enable_n) master_ff <= 1'b1;
      input_full_n <= 1'b1;
      output_empty_n <= 1'b0;
      stk.delete();
      so_cnt <= 2'h0;
    end else begin
      if (parallel_load) begin
        in_ff <= array_d;
        input_full_n <= 1'b0;
      end else if (step && !transfer_to_stack_n && !input_full_n && stk.size() < 62
                   && (master_ff || !serial_in_enable_n)) begin
        stk.push_back(in_ff);
        input_full_n <= 1'b1;
      end
      // load output register; a slave keeps empty low
      if (step && transfer_out_parallel && !output_empty_n && stk.size() > 0 && master_ff) begin
        array_q <= stk.pop_front();
        output_empty_n <= 1'b1;
      end else if (step && !transfer_out_parallel) output_empty_n <= 1'b0;
      // fourth falling shift edge empties the output register
      so_clk_q <= serial_out_shift_clock;
      if (so_clk_q && !serial_out_shift_clock && output_empty_n) begin
        so_cnt <= so_cnt + 2'h1;
        if (so_cnt == 2'h3) output_empty_n <= 1'b0;
      end
    end
  end
endmodule : fei_slice_model

// ### sim/tb_fei_host.sv
// self-checking bench for the host controller
// assumes one slice row and column, the slice model on the array pins
`timescale 1ns/1ps
module tb_fei_host;
  import fei_pkg::*;
  localparam int unsigned DW = SLICE_BITS;
  localparam int unsigned DEPTH = SLICE_WORDS + 1;
  logic core_clk = 0, reset_n = 0, wr_valid = 0, rd_ready = 0, step = 1, rd_en = 0, slow = 0;
  logic [DW-1:0] wr_data = '0, rd_data, array_d, array_q;
  logic [6:0] words_held;
  logic wr_ready, rd_valid, array_ready, master_reset_n, parallel_load, transfer_out_parallel;
  logic transfer_to_stack_n, transfer_out_serial_n, serial_in_enable_n, serial_in_shift_clock;
  logic serial_out_shift_clock, last_input_full_n, last_output_empty_n;
  logic top_input_full_n, top_output_empty_n;
  int n_fail = 0, n_checks = 0, seed = 11613, n_rd = 0, n_ok, ok;
  logic [DW-1:0] exp_q[$];
  assign top_input_full_n = last_input_full_n;
  assign top_output_empty_n = last_output_empty_n;
  always #25 core_clk = ~core_clk;
  fei_host dut_u (
    .core_clk               (core_clk),
    .reset_n                (reset_n),
    .wr_valid               (wr_valid),
    .wr_data                (wr_data),
    .wr_ready               (wr_ready),
    .rd_valid               (rd_valid),
    .rd_data                (rd_data),
    .rd_ready               (rd_ready),
    .words_held             (words_held),
    .array_ready            (array_ready),
    .master_reset_n         (master_reset_n),
    .parallel_load          (parallel_load),
    .array_d                (array_d),
    .transfer_out_parallel  (transfer_out_parallel),
    .transfer_to_stack_n    (transfer_to_stack_n),
    .transfer_out_serial_n  (transfer_out_serial_n),
    .serial_in_enable_n     (serial_in_enable_n),
    .serial_in_shift_clock  (serial_in_shift_clock),
    .serial_out_shift_clock (serial_out_shift_clock),
    .last_input_full_n      (last_input_full_n),
    .last_output_empty_n    (last_output_empty_n),
    .top_input_full_n       (top_input_full_n),
    .top_output_empty_n     (top_output_empty_n),
    .array_q                (array_q)
  );
  fei_slice_model slice_u (.core_clk, .step, .master_reset_n, .parallel_load, .array_d,
    .transfer_to_stack_n, .transfer_out_parallel, .serial_in_enable_n, .array_q,
    .serial_out_shift_clock,
    .input_full_n(last_input_full_n), .output_empty_n(last_output_empty_n));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic put_word(input logic [DW-1:0] w, output int got);
    got = 0;
    @(negedge core_clk);
    wr_data = w;
    wr_valid = 1;
    for (int k = 0; k < 100 && got == 0; k++) begin
      @(posedge core_clk);
      if (wr_ready === 1'b1) begin
        exp_q.push_back(w);
        got = 1;
      end
    end
    @(negedge core_clk);
    wr_valid = 0;
  endtask : put_word
  task automatic wait_reads(input int n);
    for (int k = 0; k < 5000 && n_rd < n; k++) @(negedge core_clk);
    check("reads", n_rd, n);
  endtask : wait_reads
  ////////////////////////////////////////
  always @(negedge core_clk) begin
    rd_ready <= rd_en && ($random(seed) % 3 != 0);
    step <= !slow || ($random(seed) % 2 != 0);
  end
  always @(posedge core_clk) begin
    if (reset_n && rd_valid === 1'b1 && rd_ready === 1'b1) begin
      check("rd_data", rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      n_rd++;
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    reset_n = 1;
    check("ies_n", serial_in_enable_n, 1'b0);
    n_ok = 0;
    for (int i = 0; i < DEPTH + 2; i++) begin
      put_word(DW'($random(seed)), ok);
      n_ok += ok;
    end
    check("taken", n_ok, DEPTH);
    check("words_held", words_held, DEPTH);
    rd_en = 1;
    wait_reads(DEPTH);
    slow = 1;
    for (int i = 0; i < 40; i++) put_word(DW'($random(seed)), ok);
    wait_reads(DEPTH + 40);
    check("words_held", words_held, 0);
    rd_en = 0;
    for (int i = 0; i < 3; i++) put_word(DW'($random(seed)), ok);
    reset_n = 0;
    repeat (4) @(negedge core_clk);
    exp_q.delete();
    n_rd = 0;
    check("mr_n", master_reset_n, 1'b0);
    reset_n = 1;
    rd_en = 1;
    for (int i = 0; i < 5; i++) put_word(DW'($random(seed)), ok);
    wait_reads(5);
    end_of_test();
  end
endmodule : tb_fei_host
